// ---- rtl/scss_clock_select.sv ----
// System clock source selector with switch control and fail-safe fallback
//
// Operation
// - Reset picks start clock from reset selection
// - Reset offers LF, HF 1MHz, HF 32MHz
// - External mode field chooses the external mode
// - External clocks: low, medium, high power
// - Crystal classes: low power, medium, high gain
// - Clock modes direct, crystal modes drive amplifier
// - Lost external clock falls back to internal
// - Crystal unused until start-up timer done
// - Software picks source while running
// - Internal block gives low and high clocks
// - Sources direct or through PLL, software-chosen
// - Old clock runs until new one ready
// - Ready sets flags and clock-switch interrupt
// - Hold bit suspends switch on old clock
// - Switch updates current, sets done, clears ready
`timescale 1ns/10ps
module scss_clock_select #(
  parameter int unsigned STARTUP_COUNT = scss_pkg::STARTUP_COUNT_DEFAULT,
  parameter int unsigned FAILSAFE_WINDOW = scss_pkg::FAILSAFE_WINDOW_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [2:0] reset_clock_select,
  input wire logic [2:0] external_osc_mode_select,
  input wire logic ext_clk_in,
  input wire logic pll_lock_in,
  input wire logic [scss_pkg::ADDR_W-1:0] addr,
  input wire logic [scss_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [scss_pkg::DATA_W-1:0] rd_data,
  output logic [2:0] current_clock_source,
  output logic [3:0] current_divider,
  output logic [2:0] ext_osc_mode,
  output logic ext_osc_enable,
  output logic crystal_drive_enable,
  output logic ext_clock_direct,
  output logic pll_enable,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_W_L = scss_pkg::IRQ_W;
  typedef struct packed {
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [1:0] lock_sync;
    scss_pkg::scss_state_t st;
    logic [2:0] cur_src;
    logic [3:0] cur_div;
    logic [2:0] req_src;
    logic [3:0] req_div;
    logic hold;
    logic [2:0] mode;
    logic new_source_ready_flag;
    logic done;
    logic [IRQ_W_L-1:0] istat;
    logic [IRQ_W_L-1:0] imask;
    logic [scss_pkg::DATA_W-1:0] rdata;
  } scss_regs_t;

  localparam logic [scss_pkg::COUNT_W-1:0] STARTUP_TERM =
    scss_pkg::COUNT_W'(STARTUP_COUNT);
  localparam logic [scss_pkg::COUNT_W-1:0] EXT_TERM =
    scss_pkg::COUNT_W'(scss_pkg::EXT_CLOCK_QUAL_COUNT);

  scss_regs_t r;
  scss_regs_t next_r;
  logic ext_edge;
  logic startup_done;
  logic fs_fail;
  logic fs_event;
  logic timer_enable;
  logic new_ready;
  logic ctrl_write;
  logic [2:0] boot_src;
  logic [3:0] boot_div;
  logic [2:0] wr_src;
  logic [3:0] wr_div;
  logic [IRQ_W_L-1:0] irq_set;

  // ----------------------------------------------------------------
  // Reset-time source decode
  // ----------------------------------------------------------------
  // Unlisted codes land on HF 1 MHz, the safe internal default
  always_comb begin
    boot_src = scss_pkg::SRC_HF;
    boot_div = scss_pkg::DIV_HF_1MHZ;
    case (reset_clock_select)
      scss_pkg::RST_SEL_HF_32MHZ: begin
        boot_src = scss_pkg::SRC_HF_PLL;
        boot_div = scss_pkg::DIV_NONE;
      end
      scss_pkg::SRC_LF, scss_pkg::SRC_EXT, scss_pkg::SRC_EXT_PLL: begin
        boot_src = reset_clock_select;
        boot_div = scss_pkg::DIV_NONE;
      end
      default: begin
        boot_src = scss_pkg::SRC_HF;
        boot_div = scss_pkg::DIV_HF_1MHZ;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // External clock qualification and supervision
  // ----------------------------------------------------------------
  // Sampled on clk, so only external clocks below 25 MHz are seen
  assign ext_edge = r.ext_sync[1] && !r.ext_prev;
  assign timer_enable = (r.st != scss_pkg::ST_BOOT) &&
    (r.mode != scss_pkg::MODE_OFF) &&
    (scss_pkg::is_ext(r.cur_src) || scss_pkg::is_ext(r.req_src));

  scss_startup_timer #(
    .COUNT_W(scss_pkg::COUNT_W)
  ) u_crystal_startup_timer (
    .clk(clk),
    .reset(reset),
    .enable(timer_enable),
    .edge_pulse(ext_edge),
    .terminal(scss_pkg::is_crystal(r.mode) ? STARTUP_TERM : EXT_TERM),
    .done(startup_done)
  );

  scss_failsafe_monitor #(
    .WINDOW(FAILSAFE_WINDOW)
  ) u_failsafe_clock_monitor (
    .clk(clk),
    .reset(reset),
    .enable(timer_enable && startup_done),
    .edge_pulse(ext_edge),
    .clear(ctrl_write),
    .fail(fs_fail),
    .fail_event(fs_event)
  );

  // Requested source ready: external qualified, PLL locked
  assign new_ready = (!scss_pkg::is_ext(r.req_src) ||
    (startup_done && !fs_fail)) &&
    (!scss_pkg::is_pll(r.req_src) || r.lock_sync[1]);
  assign ctrl_write = wr_en && (addr == scss_pkg::REG_CTRL);
  assign wr_src = wr_data[scss_pkg::SRC_LSB +: 3];
  assign wr_div = wr_data[scss_pkg::DIV_LSB +: 4];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    irq_set = '0;
    next_r.ext_sync = {r.ext_sync[0], ext_clk_in};
    next_r.ext_prev = r.ext_sync[1];
    next_r.lock_sync = {r.lock_sync[0], pll_lock_in};
    next_r.rdata = '0;
    case (r.st)
      scss_pkg::ST_BOOT: begin
        next_r.mode = external_osc_mode_select;
        next_r.req_src = boot_src;
        next_r.req_div = boot_div;
        next_r.cur_div = boot_div;
        if (scss_pkg::is_ext(boot_src) &&
            scss_pkg::is_crystal(external_osc_mode_select)) begin
          next_r.cur_src = scss_pkg::SRC_HF;
          next_r.st = scss_pkg::ST_WAIT;
        end else begin
          next_r.cur_src = boot_src;
          next_r.st = scss_pkg::ST_IDLE;
        end
      end
      scss_pkg::ST_WAIT: begin
        if (new_ready) begin
          next_r.new_source_ready_flag = 1'b1;
          irq_set[scss_pkg::IRQ_SWITCH_BIT] = 1'b1;
          next_r.st = scss_pkg::ST_HOLD;
        end
      end
      scss_pkg::ST_HOLD: begin
        if (!r.hold) begin
          next_r.cur_src = r.req_src;
          next_r.cur_div = r.req_div;
          next_r.done = 1'b1;
          next_r.new_source_ready_flag = 1'b0;
          next_r.st = scss_pkg::ST_IDLE;
        end
      end
      scss_pkg::ST_IDLE: begin
        next_r.st = scss_pkg::ST_IDLE;
      end
      default: begin
        next_r.st = scss_pkg::ST_IDLE;
      end
    endcase
    // Software request; a hold-only write leaves a pending switch alone
    if (ctrl_write && r.st != scss_pkg::ST_BOOT) begin
      next_r.hold = wr_data[scss_pkg::CTRL_HOLD_BIT];
      if (wr_src != r.req_src || wr_div != r.req_div) begin
        next_r.req_src = wr_src;
        next_r.req_div = wr_div;
        next_r.new_source_ready_flag = 1'b0;
        if (wr_src == r.cur_src && wr_div == r.cur_div) begin
          next_r.st = scss_pkg::ST_IDLE;
        end else begin
          next_r.done = 1'b0;
          next_r.st = scss_pkg::ST_WAIT;
        end
      end
    end
    // Fallback wins over any switch in the same cycle
    if (fs_fail && scss_pkg::is_ext(r.cur_src)) begin
      next_r.cur_src = scss_pkg::SRC_HF;
      next_r.cur_div = scss_pkg::DIV_HF_1MHZ;
    end
    irq_set[scss_pkg::IRQ_FAIL_BIT] = fs_event;
    // Read clears status, but an event in the same cycle survives
    if (rd_en && addr == scss_pkg::REG_ISTAT) begin
      next_r.istat = irq_set;
    end else begin
      next_r.istat = r.istat | irq_set;
    end
    if (wr_en && addr == scss_pkg::REG_IMASK) begin
      next_r.imask = wr_data[IRQ_W_L-1:0];
    end
    // Read data for the cycle after the strobe; unmapped reads zero
    if (rd_en) begin
      case (addr)
        scss_pkg::REG_CTRL: begin
          next_r.rdata[scss_pkg::SRC_LSB +: 3] = r.req_src;
          next_r.rdata[scss_pkg::DIV_LSB +: 4] = r.req_div;
          next_r.rdata[scss_pkg::CTRL_HOLD_BIT] = r.hold;
        end
        scss_pkg::REG_STAT: begin
          next_r.rdata[scss_pkg::SRC_LSB +: 3] = r.cur_src;
          next_r.rdata[scss_pkg::DIV_LSB +: 4] = r.cur_div;
          next_r.rdata[scss_pkg::STAT_NEW_SOURCE_READY_FLAG_BIT] = r.new_source_ready_flag;
          next_r.rdata[scss_pkg::STAT_DONE_BIT] = r.done;
          next_r.rdata[scss_pkg::STAT_FAIL_BIT] = fs_fail;
          next_r.rdata[scss_pkg::STAT_STARTUP_BIT] = startup_done;
        end
        scss_pkg::REG_ISTAT: begin
          next_r.rdata[IRQ_W_L-1:0] = r.istat;
        end
        scss_pkg::REG_IMASK: begin
          next_r.rdata[IRQ_W_L-1:0] = r.imask;
        end
        default: begin
          next_r.rdata = '0;
        end
      endcase
    end
  end

  // Reset state: internal HF 1 MHz until the selection is captured
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '{st: scss_pkg::ST_BOOT, cur_src: scss_pkg::SRC_HF,
             cur_div: scss_pkg::DIV_HF_1MHZ, req_src: scss_pkg::SRC_HF,
             req_div: scss_pkg::DIV_HF_1MHZ, mode: scss_pkg::MODE_OFF,
             default: '0};
    end else begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data = r.rdata;
  assign current_clock_source = r.cur_src;
  assign current_divider = r.cur_div;
  assign ext_osc_mode = r.mode;
  assign ext_osc_enable = timer_enable;
  assign crystal_drive_enable = timer_enable &&
    scss_pkg::is_crystal(r.mode);
  assign ext_clock_direct = timer_enable &&
    !scss_pkg::is_crystal(r.mode);
  assign pll_enable = scss_pkg::is_pll(r.cur_src) ||
    scss_pkg::is_pll(r.req_src);
  assign irq = |(r.istat & r.imask);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence seq_ready_seen;
    r.st == scss_pkg::ST_WAIT && new_ready;
  endsequence
  sequence seq_flags_up;
    r.new_source_ready_flag && r.istat[scss_pkg::IRQ_SWITCH_BIT] &&
    r.st == scss_pkg::ST_HOLD;
  endsequence

  AST_BOOT_SELECT: assert property (
    (r.st == scss_pkg::ST_BOOT && !scss_pkg::is_ext(boot_src))
    |=> r.cur_src == $past(boot_src) && r.st == scss_pkg::ST_IDLE)
    else $error("reset selection not applied");
  AST_WAIT_KEEPS_OLD: assert property (
    (r.st == scss_pkg::ST_WAIT && !fs_fail)
    |=> $stable(r.cur_src) && $stable(r.cur_div))
    else $error("clock changed before new source ready");
  AST_READY_FLAGS: assert property (
    (seq_ready_seen and !ctrl_write) |=> seq_flags_up)
    else $error("ready flags not set");
  AST_IRQ_RAISED: assert property (
    (seq_ready_seen and !ctrl_write and
     r.imask[scss_pkg::IRQ_SWITCH_BIT] and !rd_en)
    |=> ##[0:1] irq)
    else $error("switch interrupt not raised");
  AST_HOLD_SUSPENDS: assert property (
    (r.st == scss_pkg::ST_HOLD && r.hold && !fs_fail && !ctrl_write)
    [*2] |-> $stable(r.cur_src) && r.new_source_ready_flag)
    else $error("switch went ahead while held");
  AST_SWITCH_UPDATE: assert property (
    (r.st == scss_pkg::ST_HOLD && !r.hold && !ctrl_write && !fs_fail)
    |=> r.cur_src == $past(r.req_src) && r.done && !r.new_source_ready_flag)
    else $error("switch did not update status");
  AST_FALLBACK: assert property (
    (fs_fail && scss_pkg::is_ext(r.cur_src))
    |=> r.cur_src == scss_pkg::SRC_HF)
    else $error("no fallback after clock loss");
  AST_CRYSTAL_WAITS: assert property (
    (r.st == scss_pkg::ST_WAIT && scss_pkg::is_ext(r.req_src) &&
     !startup_done) |=> r.st != scss_pkg::ST_HOLD)
    else $error("crystal used before start-up done");

endmodule : scss_clock_select

// ---- rtl/scss_pkg.sv ----
// Shared constants, types and decode functions of the clock source selector
package scss_pkg;

  // ----------------------------------------------------------------
  // Register port geometry and offsets
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_ISTAT = 4'h8;
  localparam logic [ADDR_W-1:0] REG_IMASK = 4'hC;

  // Field positions
  localparam int unsigned SRC_LSB = 0;
  localparam int unsigned DIV_LSB = 4;
  localparam int unsigned CTRL_HOLD_BIT = 8;
  localparam int unsigned STAT_NEW_SOURCE_READY_FLAG_BIT = 8;
  localparam int unsigned STAT_DONE_BIT = 9;
  localparam int unsigned STAT_FAIL_BIT = 10;
  localparam int unsigned STAT_STARTUP_BIT = 11;
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_SWITCH_BIT = 0;
  localparam int unsigned IRQ_FAIL_BIT = 1;

  // ----------------------------------------------------------------
  // Clock sources, reset selections, dividers, external modes
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_HF_PLL = 3'h0;
  localparam logic [2:0] SRC_EXT_PLL = 3'h2;
  localparam logic [2:0] SRC_LF = 3'h5;
  localparam logic [2:0] SRC_HF = 3'h6;
  localparam logic [2:0] SRC_EXT = 3'h7;
  localparam logic [2:0] RST_SEL_HF_32MHZ = 3'h0;
  localparam logic [2:0] RST_SEL_HF_1MHZ = 3'h6;
  localparam logic [3:0] DIV_NONE = 4'h0;
  localparam logic [3:0] DIV_HF_1MHZ = 4'h5;
  localparam logic [2:0] MODE_EXT_CLOCK_HIGH_POWER = 3'h7;
  localparam logic [2:0] MODE_EXT_CLOCK_MEDIUM_POWER = 3'h6;
  localparam logic [2:0] MODE_EXT_CLOCK_LOW_POWER = 3'h5;
  localparam logic [2:0] MODE_OFF = 3'h4;
  localparam logic [2:0] MODE_HIGH_GAIN_CRYSTAL = 3'h2;
  localparam logic [2:0] MODE_MEDIUM_GAIN_CRYSTAL = 3'h1;
  localparam logic [2:0] MODE_LOW_POWER_CRYSTAL = 3'h0;

  // Timing defaults: start-up counts in external clock edges, fail-safe window in clk cycles
  localparam int unsigned STARTUP_COUNT_DEFAULT = 1024;
  localparam int unsigned EXT_CLOCK_QUAL_COUNT = 1;
  localparam int unsigned FAILSAFE_WINDOW_DEFAULT = 64;
  localparam int unsigned COUNT_W = 16;

  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_WAIT, ST_HOLD} scss_state_t;

  // Source runs from the external pin
  function automatic logic is_ext(input logic [2:0] src);
    return (src == SRC_EXT) || (src == SRC_EXT_PLL);
  endfunction : is_ext

  // Source runs through a PLL
  function automatic logic is_pll(input logic [2:0] src);
    return (src == SRC_EXT_PLL) || (src == SRC_HF_PLL);
  endfunction : is_pll

  // External mode needs a crystal or resonator
  function automatic logic is_crystal(input logic [2:0] mode);
    return (mode == MODE_HIGH_GAIN_CRYSTAL) ||
           (mode == MODE_MEDIUM_GAIN_CRYSTAL) ||
           (mode == MODE_LOW_POWER_CRYSTAL);
  endfunction : is_crystal

endpackage : scss_pkg

// ---- rtl/scss_startup_timer.sv ----
// Start-up qualification counter for the external oscillator
`timescale 1ns/10ps
module scss_startup_timer #(
  parameter int unsigned COUNT_W = scss_pkg::COUNT_W
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic edge_pulse,
  input wire logic [COUNT_W-1:0] terminal,
  output logic done
);

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic done;
  } scss_timer_t;

  scss_timer_t r;
  scss_timer_t next_r;

  // Count edges while enabled; disabling restarts qualification
  always_comb begin
    next_r = r;
    if (!enable) begin
      next_r = '0;
    end else if (edge_pulse && !r.done) begin
      next_r.count = r.count + 1'b1;
      if (r.count + 1'b1 >= terminal) begin
        next_r.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign done = r.done;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_DONE_AFTER_COUNT: assert property (
    @(posedge clk) disable iff (reset)
    $rose(r.done) |-> $past(r.count) + 1'b1 >= terminal && $past(edge_pulse))
    else $error("startup done raised before terminal count");

endmodule : scss_startup_timer

// ---- rtl/scss_failsafe_monitor.sv ----
// Watchdog on the external clock edges, latching a failure
`timescale 1ns/10ps
module scss_failsafe_monitor #(
  parameter int unsigned WINDOW = scss_pkg::FAILSAFE_WINDOW_DEFAULT
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic edge_pulse,
  input wire logic clear,
  output logic fail,
  output logic fail_event
);

  localparam logic [scss_pkg::COUNT_W-1:0] LIMIT =
    scss_pkg::COUNT_W'(WINDOW - 1);

  typedef struct packed {
    logic [scss_pkg::COUNT_W-1:0] idle;
    logic fail;
  } scss_fsmon_t;

  scss_fsmon_t r;
  scss_fsmon_t next_r;
  logic trip;

  // Any edge restarts the window; failure stays until cleared
  always_comb begin
    next_r = r;
    trip = 1'b0;
    if (!enable || edge_pulse) begin
      next_r.idle = '0;
    end else if (r.idle == LIMIT) begin
      trip = !r.fail;
    end else begin
      next_r.idle = r.idle + 1'b1;
    end
    if (trip) begin
      next_r.fail = 1'b1;
    end else if (clear) begin
      next_r.fail = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign fail = r.fail;
  assign fail_event = trip;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_NO_EARLY_FAIL: assert property (
    @(posedge clk) disable iff (reset)
    (edge_pulse && enable) |=> !trip)
    else $error("failure declared right after an edge");

endmodule : scss_failsafe_monitor

// ---- verification/scss_ext_osc_model.sv ----
// External crystal or clock driver model with a PLL lock source
`timescale 1ns/10ps
module scss_ext_osc_model #(
  parameter int unsigned HALF_NS = 100
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic run,
  input wire logic pll_en,
  output logic osc_out,
  output logic pll_lock
);
  logic [3:0] lock_cnt;

  // --------------------------------------------------------------
  // Oscillator pin
  // --------------------------------------------------------------
  // Runs only while the pin is enabled; stands low otherwise
  initial begin
    osc_out = 1'b0;
    forever begin
      #(HALF_NS);
      if (enable && run) begin
        osc_out = ~osc_out;
      end else begin
        osc_out = 1'b0;
      end
    end
  end

  // --------------------------------------------------------------
  // PLL lock
  // --------------------------------------------------------------
  // Lock takes a while, so a switch must wait for it
  always_ff @(posedge clk or posedge reset) begin
    if (reset || !pll_en) begin
      lock_cnt <= 4'h0;
    end else if (lock_cnt != 4'hF) begin
      lock_cnt <= lock_cnt + 4'h1;
    end
  end
  assign pll_lock = (lock_cnt == 4'hF);
endmodule : scss_ext_osc_model

// ---- verification/scss_clock_select_tb.sv ----
// Self-checking bench of the clock source selector
`timescale 1ns/10ps
module scss_clock_select_tb;
  logic clk, reset, ext_clk_in, pll_lock_in, wr_en, rd_en, run;
  logic [2:0] rst_sel, mode_sel;
  logic [3:0] addr;
  logic [15:0] wr_data, rd_data, rdv;
  logic [2:0] cur_src, ext_mode;
  logic [3:0] cur_div;
  logic osc_en, xtal_en, direct, pll_en, irq;
  int n_mismatch = 0;
  int tests_run = 0;

  // --------------------------------------------------------------
  // Design and far side
  // --------------------------------------------------------------
  // Short start-up count keeps crystal runs brief
  scss_clock_select #(.STARTUP_COUNT(4), .FAILSAFE_WINDOW(16))
  i_scss_clock_select (.clk(clk), .reset(reset),
    .reset_clock_select(rst_sel), .external_osc_mode_select(mode_sel),
    .ext_clk_in(ext_clk_in), .pll_lock_in(pll_lock_in), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .current_clock_source(cur_src), .current_divider(cur_div),
    .ext_osc_mode(ext_mode), .ext_osc_enable(osc_en),
    .crystal_drive_enable(xtal_en), .ext_clock_direct(direct),
    .pll_enable(pll_en), .irq(irq));
  scss_ext_osc_model i_scss_ext_osc_model (.clk(clk), .reset(reset),
    .enable(osc_en), .run(run), .pll_en(pll_en), .osc_out(ext_clk_in),
    .pll_lock(pll_lock_in));

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic boot(input logic [2:0] s, input logic [2:0] m);
    @(posedge clk);
    reset <= 1'b1;
    rst_sel <= s;
    mode_sel <= m;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : boot

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    rdv = rd_data;
  endtask : rd

  // Bounded wait for a current source
  task automatic wait_cur(input logic [2:0] s, input int n);
    int i;
    i = 0;
    while (cur_src !== s && i < n) begin
      @(posedge clk);
      #1;
      i++;
    end
  endtask : wait_cur

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // Reset selections and the fallback code for others
  task automatic t_boot();
    boot(3'h0, 3'h4);
    chk({cur_div, 1'b0, cur_src}, 16'h0000);
    boot(3'h5, 3'h4);
    chk({cur_div, 1'b0, cur_src}, 16'h0005);
    boot(3'h6, 3'h4);
    chk({cur_div, 1'b0, cur_src}, 16'h0056);
    boot(3'h3, 3'h4);
    chk({cur_div, 1'b0, cur_src}, 16'h0056);
    $display("boot test done");
  endtask : t_boot

  // Internal switch: flags, interrupt, read-clear, map edges
  task automatic t_switch();
    wr(4'hC, 16'h0003);
    rd(4'hC);
    chk(rdv, 16'h0003);
    rd(4'h2);
    chk(rdv, 16'h0000);
    wr(4'h0, 16'h0005);
    @(posedge clk);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    chk({13'h0000, cur_src}, 16'h0006);
    @(posedge clk);
    #1;
    chk({13'h0000, cur_src}, 16'h0005);
    rd(4'h4);
    chk(rdv & 16'h07FF, 16'h0205);
    rd(4'h8);
    chk(rdv, 16'h0001);
    rd(4'h8);
    chk(rdv, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    $display("switch test done");
  endtask : t_switch

  // Hold parks the switch on the old clock
  task automatic t_hold();
    wr(4'h0, 16'h0156);
    repeat (10) @(posedge clk);
    #1;
    chk({13'h0000, cur_src}, 16'h0005);
    rd(4'h4);
    chk(rdv & 16'h0300, 16'h0100);
    wr(4'h0, 16'h0056);
    wait_cur(3'h6, 10);
    chk({cur_div, 1'b0, cur_src}, 16'h0056);
    $display("hold test done");
  endtask : t_hold

  // PLL target waits for lock before it takes over
  task automatic t_pll();
    wr(4'h0, 16'h0000);
    repeat (3) @(posedge clk);
    #1;
    chk({14'h0000, pll_en, cur_src == 3'h6}, 16'h0003);
    wait_cur(3'h0, 60);
    chk({cur_div, 1'b0, cur_src}, 16'h0000);
    $display("pll test done");
  endtask : t_pll

  // Every external mode; crystal ones wait for the timer
  task automatic t_ext();
    logic [2:0] modes [6];
    logic xt;
    modes = '{3'h5, 3'h6, 3'h7, 3'h0, 3'h2, 3'h1};
    foreach (modes[k]) begin
      boot(3'h6, modes[k]);
      run <= 1'b1;
      xt = (modes[k] < 3'h3);
      wr(4'h0, 16'h0007);
      repeat (2) @(posedge clk);
      #1;
      chk({13'h0000, ext_mode}, {13'h0000, modes[k]});
      chk({13'h0000, osc_en, xtal_en, direct},
          {13'h0000, 1'b1, xt, !xt});
      if (xt) begin
        repeat (13) @(posedge clk);
        #1;
        chk({13'h0000, cur_src}, 16'h0006);
      end
      wait_cur(3'h7, 200);
      chk({cur_div, 1'b0, cur_src}, 16'h0007);
      $display("external mode test done");
    end
    // Crystal chosen at reset runs on HF until start-up completes
    boot(3'h7, 3'h1);
    chk({cur_div, 1'b0, cur_src}, 16'h0006);
    wait_cur(3'h7, 200);
    chk({cur_div, 1'b0, cur_src}, 16'h0007);
    // Stop the crystal and expect the fallback
    wr(4'hC, 16'h0002);
    run <= 1'b0;
    wait_cur(3'h6, 100);
    chk({cur_div, 1'b0, cur_src}, 16'h0056);
    chk({15'h0000, irq}, 16'h0001);
    rd(4'h4);
    chk(rdv & 16'h0400, 16'h0400);
    rd(4'h8);
    chk(rdv & 16'h0002, 16'h0002);
    $display("failsafe test done");
  endtask : t_ext

  // --------------------------------------------------------------
  // Verdict and run control
  // --------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // Main sequence; every input starts defined
  initial begin
    reset = 1'b1;
    rst_sel = 3'h6;
    mode_sel = 3'h4;
    addr = 4'h0;
    wr_data = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    run = 1'b0;
    t_boot();
    t_switch();
    t_hold();
    t_pll();
    t_ext();
    complete_run();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #1000000;
    n_mismatch++;
    complete_run();
  end
endmodule : scss_clock_select_tb
